// file: hdl/touch_pkg.sv
package touch_pkg;
    // ******************************
    // addresses and switch codes
    // ******************************
    localparam logic [6:0] HID_ADDR_DEFAULT = 7'h51;
    localparam logic [6:0] VENDOR_ADDR_DEFAULT = 7'h50;
    localparam logic [6:0] BLANK_ADDR = 7'h00;
    localparam logic [7:0] HID_DISABLE = 8'hFF;
    localparam logic [7:0] EMPTY_READ = 8'hFF;
    localparam logic [15:0] HID_DESC_REG = 16'h0001;
    // ******************************
    // buffering and timing
    // ******************************
    localparam int TX_BUF_BYTES = 128;
    localparam int STAGE_DEPTH = 4;
    localparam int CLOCK_KHZ = 10000;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_MIN_PERIOD_CYCLES = CLOCK_KHZ / SCL_MAX_KHZ;

    typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, RX, RX_ACK, TX, TX_ACK, WAIT} i2c_state_e;
endpackage : touch_pkg

// file: hdl/touch_module_i2c_slave_port.sv
`timescale 1ns/1ps
// ******************************
// generic fifo, flop storage
// ******************************
module fifo_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic push;
    logic pop;

    assign inReady = count != ($clog2(DEPTH+1))'(DEPTH);
    assign outValid = count != '0;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr];

    always_ff @(posedge clock)
    begin
        if (push)
            mem[wrPtr] <= inData;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            // pointers wrap only for power-of-two depths
            if (push)
                wrPtr <= wrPtr + 1'b1;
            if (pop)
                rdPtr <= rdPtr + 1'b1;
            count <= count + (($clog2(DEPTH+1))'(push)) - (($clog2(DEPTH+1))'(pop));
        end
    end
endmodule : fifo_buf

// ******************************
// i2c slave port, two functions
// ******************************
module touch_module_i2c_slave_port
    import touch_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic irqN,
    input wire logic [6:0] hidAddrSw,
    input wire logic [6:0] vendorAddrSw,
    input wire logic [7:0] hidFunctionConfigSwitch,
    input wire logic tdValid,
    output logic tdReady,
    input wire logic [7:0] tdData,
    input wire logic tdFirst,
    input wire logic [2:0] tdLen,
    output logic [7:0] cmdData,
    output logic cmdValid,
    input wire logic cmdBusy,
    output logic [15:0] hidReg,
    output logic hidDescSel,
    output logic [7:0] hidWrData,
    output logic hidWrValid,
    input wire logic [7:0] hidRdData,
    output logic hidRdStrobe,
    input wire logic hidIrqReq
);
    i2c_state_e state;
    logic [2:0] sclS;
    logic [2:0] sdaS;
    logic sclF;
    logic sdaF;
    logic next_scl;
    logic next_sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rw;
    logic isHid;
    logic [1:0] wrIdx;
    logic stretch;
    logic hidOn;
    logic hidHit;
    logic venHit;
    logic [6:0] hidAddr;
    logic [6:0] venAddr;
    logic loadTx;
    logic rxDone;
    logic [7:0] txByte;
    logic stValid;
    logic stReady;
    logic [11:0] stData;
    logic keep;
    logic accept;
    logic effKeep;
    logic bufInReady;
    logic bufValid;
    logic bufPop;
    logic [7:0] bufData;
    logic [7:0] bufCount;

    // ******************************
    // pin synchronisers and events
    // ******************************
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sclS <= 3'h7;
            sdaS <= 3'h7;
            sclF <= 1'b1;
            sdaF <= 1'b1;
        end
        else
        begin
            sclS <= {sclS[1:0], sclIn};
            sdaS <= {sdaS[1:0], sdaIn};
            sclF <= next_scl;
            sdaF <= next_sda;
        end
    end

    // glitch filter: stages two and three must agree
    assign next_scl = (sclS[1] == sclS[2]) ? sclS[2] : sclF;
    assign next_sda = (sdaS[1] == sdaS[2]) ? sdaS[2] : sdaF;
    assign rise = !sclF && next_scl;
    assign fall = sclF && !next_scl;
    assign start = sclF && next_scl && sdaF && !next_sda;
    assign stop = sclF && next_scl && !sdaF && next_sda;

    // ******************************
    // address match
    // ******************************
    assign hidOn = hidFunctionConfigSwitch != HID_DISABLE;
    // switches are quasi-static; a blank switch falls back to the default
    assign hidAddr = (hidAddrSw == BLANK_ADDR) ? HID_ADDR_DEFAULT : hidAddrSw;
    assign venAddr = (vendorAddrSw == BLANK_ADDR) ? VENDOR_ADDR_DEFAULT : vendorAddrSw;
    assign hidHit = hidOn && (sh[7:1] == hidAddr);
    assign venHit = sh[7:1] == venAddr;

    assign loadTx = fall && ((state == ADDR_ACK && rw) || state == TX_ACK);
    assign rxDone = fall && state == RX && cnt == 4'h8;
    assign txByte = isHid ? hidRdData : (bufValid ? bufData : EMPTY_READ);
    assign bufPop = loadTx && !isHid && bufValid;
    assign hidRdStrobe = loadTx && isHid;

    // ******************************
    // byte-level state machine
    // ******************************
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= IDLE;
            sh <= 8'h00;
            cnt <= 4'h0;
            rw <= 1'b0;
            isHid <= 1'b0;
        end
        else if (start)
        begin
            state <= ADDR;
            cnt <= 4'h0;
        end
        else if (stop)
            state <= IDLE;
        else
        begin
            case (state)
                ADDR, RX:
                begin
                    if (rise)
                    begin
                        sh <= {sh[6:0], next_sda};
                        cnt <= cnt + 4'h1;
                    end
                    if (fall && cnt == 4'h8 && state == RX)
                        state <= RX_ACK;
                    else if (fall && cnt == 4'h8)
                    begin
                        state <= (hidHit || venHit) ? ADDR_ACK : IDLE;
                        rw <= sh[0];
                        isHid <= hidHit;
                    end
                end
                ADDR_ACK, RX_ACK:
                begin
                    if (fall)
                    begin
                        state <= (state == ADDR_ACK && rw) ? TX : RX;
                        cnt <= 4'h0;
                    end
                    if (loadTx)
                        sh <= txByte;
                end
                TX:
                begin
                    if (fall)
                    begin
                        sh <= {sh[6:0], 1'b1};
                        cnt <= cnt + 4'h1;
                        if (cnt == 4'h7)
                            state <= TX_ACK;
                    end
                end
                TX_ACK:
                begin
                    if (rise && next_sda)
                        state <= WAIT;
                    else if (fall)
                    begin
                        state <= TX;
                        cnt <= 4'h0;
                        sh <= txByte;
                    end
                end
                default:
                    state <= state;
            endcase
        end
    end

    // open drain: only ever pull low
    assign sdaOut = 1'b0;
    assign sclOut = 1'b0;
    assign sdaOe = (state == ADDR_ACK || state == RX_ACK) || (state == TX && !sh[7]);
    assign sclOe = stretch;

    // ******************************
    // received bytes and stretch
    // ******************************
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wrIdx <= 2'h0;
            cmdData <= 8'h00;
            cmdValid <= 1'b0;
            hidReg <= 16'h0000;
            hidWrData <= 8'h00;
            hidWrValid <= 1'b0;
        end
        else
        begin
            cmdValid <= rxDone && !isHid;
            hidWrValid <= rxDone && isHid && wrIdx == 2'h2;
            if (start)
                wrIdx <= 2'h0;
            else if (rxDone && isHid && wrIdx != 2'h2)
                wrIdx <= wrIdx + 2'h1;
            if (rxDone && !isHid)
                cmdData <= sh;
            if (rxDone && isHid && wrIdx == 2'h0)
                hidReg[7:0] <= sh;
            if (rxDone && isHid && wrIdx == 2'h1)
                hidReg[15:8] <= sh;
            if (rxDone && isHid && wrIdx == 2'h2)
                hidWrData <= sh;
        end
    end

    assign hidDescSel = hidReg == HID_DESC_REG;

    // hold SCL low after the ack of a vendor command until it is done
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            stretch <= 1'b0;
        else if (state == RX_ACK && fall && !isHid && cmdBusy)
            stretch <= 1'b1;
        else if (!cmdBusy)
            stretch <= 1'b0;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            irqN <= 1'b1;
        else
            irqN <= hidOn ? !hidIrqReq : !bufValid;
    end

    // ******************************
    // touch queue with discard
    // ******************************
    fifo_buf #(.WIDTH(12), .DEPTH(STAGE_DEPTH)) stage (
        .clock(clock),
        .rst(rst),
        .inValid(tdValid),
        .inReady(tdReady),
        .inData({tdFirst, tdLen, tdData}),
        .outValid(stValid),
        .outReady(stReady),
        .outData(stData),
        .count()
    );

    // whole action is judged on its first byte so no partial action is queued
    assign accept = (9'(bufCount) + 9'(stData[10:8])) <= 9'(TX_BUF_BYTES);
    assign effKeep = stData[11] ? accept : keep;
    assign stReady = !effKeep || bufInReady;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            keep <= 1'b0;
        else if (stValid && stReady && stData[11])
            keep <= accept;
    end

    fifo_buf #(.WIDTH(8), .DEPTH(TX_BUF_BYTES)) txq (
        .clock(clock),
        .rst(rst),
        .inValid(stValid && effKeep),
        .inReady(bufInReady),
        .inData(stData[7:0]),
        .outValid(bufValid),
        .outReady(bufPop),
        .outData(bufData),
        .count(bufCount)
    );

    // ******************************
    // assertions
    // ******************************
    // scl is only ever held right after a vendor byte ack, before any new bit
    a_slave_only:
        assert property (@(posedge clock) disable iff (rst)
            sclOe |-> state == RX && cnt == 4'h0 && !isHid)
        else $error("scl held outside a vendor ack");
    a_stretch_release:
        assert property (@(posedge clock) disable iff (rst) stretch && !cmdBusy |=> !sclOe)
        else $error("stretch not released");
    a_irq_vendor_owner:
        assert property (@(posedge clock) disable iff (rst)
            !hidOn && $stable(hidFunctionConfigSwitch) |=> irqN == !$past(bufValid))
        else $error("vendor irq wrong");
    a_irq_hid_owner:
        assert property (@(posedge clock) disable iff (rst) hidOn |=> irqN == !$past(hidIrqReq))
        else $error("hid irq wrong");
    a_empty_reads_ff:
        assert property (@(posedge clock) disable iff (rst)
            loadTx && !isHid && !bufValid |=> sh == EMPTY_READ)
        else $error("empty read not FF");
    a_addr_ack:
        assert property (@(posedge clock) disable iff (rst)
            state == ADDR && fall && cnt == 4'h8 && venHit && !start && !stop
            |=> state == ADDR_ACK && sdaOe)
        else $error("address not acked");
    a_read_nack_end:
        assert property (@(posedge clock) disable iff (rst)
            state == TX_ACK && rise && next_sda && !start && !stop |=> state == WAIT ##1 !sdaOe)
        else $error("nack did not end read");
    a_drop_action:
        assert property (@(posedge clock) disable iff (rst)
            stValid && stData[11] && !accept
            |-> stReady ##1 bufCount == $past(bufCount) - 8'($past(bufPop)))
        else $error("action queued without room");
    a_dir_bit:
        assert property (@(posedge clock) disable iff (rst)
            state == ADDR && fall && cnt == 4'h8 && !start && !stop |=> rw == $past(sh[0]))
        else $error("direction bit lost");
endmodule : touch_module_i2c_slave_port

// file: verification/i2c_host_model.sv
`timescale 1ns/1ps
// ******************************
// host master, bit-banged
// ******************************
module i2c_host_model (
    input wire logic clock,
    input wire logic scl,
    input wire logic sda,
    output logic sclLow,
    output logic sdaLow
);
    // low time 17 clocks, keeps above the 13 clock minimum
    localparam int HALF = 15;
    // bus free time between a stop and the next start
    localparam int BUS_FREE = 200;
    initial
    begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask : tick
    task automatic sclUp();
        int i;
        sclLow = 1'b0;
        // no further edge while the device stretches
        for (i = 0; i < 3000 && scl !== 1'b1; i++)
            tick(1);
    endtask : sclUp
    task automatic bitIo(input logic b, output logic r);
        sdaLow = !b;
        tick(HALF);
        sclUp();
        tick(HALF);
        r = sda;
        sclLow = 1'b1;
        tick(2);
    endtask : bitIo
    task automatic sendStart();
        sdaLow = 1'b0;
        tick(HALF);
        sclUp();
        tick(HALF);
        sdaLow = 1'b1;
        tick(HALF);
        sclLow = 1'b1;
        tick(2);
    endtask : sendStart
    task automatic sendStop();
        sdaLow = 1'b1;
        tick(HALF);
        sclUp();
        tick(HALF);
        sdaLow = 1'b0;
        tick(BUS_FREE);
    endtask : sendStop
    task automatic writeByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitIo(d[i], r);
        bitIo(1'b1, r);
        ack = !r;
    endtask : writeByte
    task automatic readByte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitIo(1'b1, r);
            d[i] = r;
        end
        bitIo(last, r);
    endtask : readByte
endmodule : i2c_host_model

// file: verification/touch_module_i2c_slave_port_bench.sv
`timescale 1ns/1ps
module touch_module_i2c_slave_port_bench;
    import touch_pkg::*;
    logic clock, rst, sclOe, sdaOe, sclOut, sdaOut, irqN, tdValid, tdReady, tdFirst;
    logic cmdValid, cmdBusy, hidDescSel, hidWrValid, hidRdStrobe, hidIrqReq;
    logic hostScl, hostSda, ack;
    logic [6:0] hidAddrSw, vendorAddrSw;
    logic [7:0] cfgSw, tdData, cmdData, hidWrData, hidRdData, rd, lfsr, d;
    logic [2:0] tdLen;
    logic [15:0] hidReg;
    wire logic scl = !(sclOe | hostScl);
    wire logic sda = !(sdaOe | hostSda);
    int miscompares, checksDone, stretch, e, strobes;
    int model[$];
    logic [7:0] cmdQ[$], hidQ[$], expQ[$];
    logic [6:0] adr[4] = '{7'h52, 7'h51, 7'h3A, 7'h50};
    logic expAck[4] = '{1'b0, 1'b0, 1'b1, 1'b0};

    touch_module_i2c_slave_port uut (.clock(clock), .rst(rst), .sclIn(scl), .sclOut(sclOut),
        .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .irqN(irqN),
        .hidAddrSw(hidAddrSw), .vendorAddrSw(vendorAddrSw), .hidFunctionConfigSwitch(cfgSw),
        .tdValid(tdValid), .tdReady(tdReady), .tdData(tdData), .tdFirst(tdFirst),
        .tdLen(tdLen), .cmdData(cmdData), .cmdValid(cmdValid), .cmdBusy(cmdBusy),
        .hidReg(hidReg), .hidDescSel(hidDescSel), .hidWrData(hidWrData),
        .hidWrValid(hidWrValid), .hidRdData(hidRdData), .hidRdStrobe(hidRdStrobe),
        .hidIrqReq(hidIrqReq));
    i2c_host_model host (.clock(clock), .scl(scl), .sda(sda), .sclLow(hostScl),
        .sdaLow(hostSda));

    initial
        clock = 1'b0;
    always #50 clock = ~clock;
    function automatic logic [7:0] lfsrNext(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsrNext
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    task automatic addr(input logic [6:0] a, input logic r);
        host.sendStart();
        host.writeByte({a, r}, ack);
    endtask : addr
    task automatic pushAction(input int len);
        logic keep;
        int j;
        keep = model.size() + len <= TX_BUF_BYTES;
        for (int k = 0; k < len; k++)
        begin
            tdValid = 1'b1;
            tdData = lfsr;
            tdFirst = k == 0;
            tdLen = 3'(len);
            j = 0;
            do @(posedge clock); while (tdReady !== 1'b1 && j++ < 200);
            if (keep)
                model.push_back(tdData);
            lfsr = lfsrNext(lfsr);
            #5;
        end
        tdValid = 1'b0;
    endtask : pushAction
    task automatic readVendor(input int n);
        addr(VENDOR_ADDR_DEFAULT, 1'b1);
        check(ack, 1);
        for (int k = 0; k < n; k++)
        begin
            host.readByte(k == n - 1, rd);
            e = model.size() ? model.pop_front() : EMPTY_READ;
            check(rd, 16'(e));
        end
        host.sendStop();
    endtask : readVendor

    // releases the stretch after 40 held cycles
    always @(posedge clock)
    begin
        if (cmdValid === 1'b1)
            cmdQ.push_back(cmdData);
        if (hidWrValid === 1'b1)
            hidQ.push_back(hidWrData);
        if (hidRdStrobe === 1'b1)
            strobes++;
        if (sclOe === 1'b1)
        begin
            stretch++;
            if (stretch == 40)
                cmdBusy <= 1'b0;
        end
    end
    initial
    begin
        repeat (95000) @(posedge clock);
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end
    initial
    begin
        rst = 1'b1;
        {hidAddrSw, vendorAddrSw, tdValid, tdData, tdFirst, tdLen} = '0;
        {cmdBusy, hidRdData, hidIrqReq, stretch} = '0;
        cfgSw = HID_DISABLE;
        lfsr = 8'h5D;
        repeat (16) @(posedge clock);
        #5;
        check({irqN, sdaOe, sclOe}, 16'h0004);
        check({sclOut, sdaOut}, 16'h0000);
        rst = 1'b0;
        repeat (4) @(posedge clock);
        #5;
        readVendor(2);
        check(irqN, 1);
        $display("test empty read done");
        cmdBusy = 1'b1;
        addr(VENDOR_ADDR_DEFAULT, 1'b0);
        check(ack, 1);
        for (int k = 0; k < 2; k++)
        begin
            d = lfsr;
            lfsr = lfsrNext(lfsr);
            expQ.push_back(d);
            host.writeByte(d, ack);
            check(ack, 1);
        end
        host.sendStop();
        check(stretch >= 40, 1);
        check(cmdQ.size(), 2);
        while (expQ.size())
            check(cmdQ.pop_front(), expQ.pop_front());
        $display("test vendor write done");
        vendorAddrSw = 7'h3A;
        for (int k = 0; k < 4; k++)
        begin
            addr(adr[k], 1'b0);
            check(ack, expAck[k]);
            host.sendStop();
        end
        vendorAddrSw = 7'h00;
        $display("test addresses done");
        for (int k = 0; k < 19; k++)
            pushAction(7);
        pushAction(2);
        repeat (10) @(posedge clock);
        #5;
        check(irqN, 0);
        readVendor(129);
        repeat (4) @(posedge clock);
        #5;
        check(irqN, 1);
        $display("test buffer done");
        cfgSw = 8'h00;
        hidIrqReq = 1'b1;
        repeat (3) @(posedge clock);
        #5;
        check(irqN, 0);
        pushAction(3);
        hidIrqReq = 1'b0;
        repeat (3) @(posedge clock);
        #5;
        check(irqN, 1);
        addr(HID_ADDR_DEFAULT, 1'b0);
        check(ack, 1);
        d = lfsr;
        hidRdData = lfsrNext(lfsr);
        foreach (expAck[k])
            if (k < 3)
            begin
                host.writeByte(k == 0 ? 8'h01 : k == 1 ? 8'h00 : d, ack);
                check(ack, 1);
            end
        check(hidReg, HID_DESC_REG);
        check(hidDescSel, 1);
        addr(HID_ADDR_DEFAULT, 1'b1);
        check(ack, 1);
        host.readByte(1'b1, rd);
        check(rd, hidRdData);
        check(16'(strobes), 16'h0001);
        host.sendStop();
        check(hidQ.pop_front(), d);
        cfgSw = HID_DISABLE;
        readVendor(4);
        $display("test hid done");
        wrap_up();
    end
endmodule : touch_module_i2c_slave_port_bench
